// file: logic/sdc_pkg.sv
// constants shared by the synchronous dram command, address and mask interface
package sdc_pkg;
  // ****************************************
  // pin widths
  // ****************************************
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int DQ_W = 16;
  localparam int BANKS = 4;
  localparam int LANES = 2;
  localparam int LANE_W = 8;

  // ****************************************
  // command codes on {row strobe, column strobe, write strobe}, all active low
  // ****************************************
  localparam logic [2:0] CMD_ACTIVE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_MODE_PROGRAM = 3'h0;

  // ****************************************
  // address field positions
  // ****************************************
  localparam int PRECHARGE_FLAG_POS = 10;
  localparam int COL_MSB = 8;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;

  // ****************************************
  // burst length codes and counts
  // ****************************************
  localparam logic [2:0] BL_CODE_1 = 3'h0;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [3:0] BL_REM_1 = 4'h0;
  localparam logic [3:0] BL_REM_2 = 4'h1;
  localparam logic [3:0] BL_REM_4 = 4'h3;
  localparam logic [3:0] BL_REM_8 = 4'h7;

  // ****************************************
  // storage model: bank, low row bits, low column bits
  // ****************************************
  localparam int MEM_ROW_BITS = 4;
  localparam int MEM_COL_BITS = 5;
  localparam int MEM_ADDR_W = BANK_W + MEM_ROW_BITS + MEM_COL_BITS;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;
  localparam logic [DQ_W-1:0] DQ_RESET = 16'h0000;

  typedef enum logic [2:0] {
    BS_IDLE = 3'b001,
    BS_READ = 3'b010,
    BS_WRITE = 3'b100
  } sdc_burst_t;
endpackage

// file: logic/sdc_beat_mem.sv
// byte-writable storage array with registered read data
`timescale 1ns/1ns
`default_nettype none
module sdc_beat_mem (
  // clock
  input wire logic clk,
  // access
  input wire logic [sdc_pkg::LANES-1:0] wrEn,
  input wire logic [sdc_pkg::MEM_ADDR_W-1:0] addr,
  input wire logic [sdc_pkg::DQ_W-1:0] wrData,
  output logic [sdc_pkg::DQ_W-1:0] rdData
);
  import sdc_pkg::*;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gLane
      logic [LANE_W-1:0] store [0:(1<<MEM_ADDR_W)-1];
      always_ff @(posedge clk) begin
        if (wrEn[g]) begin
          store[addr] <= wrData[g*LANE_W +: LANE_W];
        end
        rdData[g*LANE_W +: LANE_W] <= store[addr];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: logic/sdc_device.sv
// command decode, bank rows, bursts and byte-lane masking of a four-bank sdram
// ****************************************
// Overview of operation
// RULE1: command decoded from select and three strobes
// RULE2: masked write lanes leave memory unchanged
// RULE3: masked read lane floats two clocks later
// RULE4: low mask owns bits 7:0, high 15:8
// RULE5: each lane mask behaves like single mask
// RULE6: bank select picks target bank
// RULE7: ACTIVE captures thirteen-bit row per bank
// RULE8: column comes from address bits 8:0
// RULE9: precharge flag bit requests auto precharge
// RULE10: PRECHARGE flag high closes all banks
// RULE11: mode program takes opcode from address
// RULE12: everything sampled on rising clock edge
// RULE13: deselect ignores commands, bursts and masks continue
// RULE14: controller opens row before read or write
// ****************************************
`timescale 1ns/1ns
`default_nettype none
module sdc_device (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command strobes
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeStrobeN,
  // bank and address
  input wire logic [sdc_pkg::BANK_W-1:0] bankSel,
  input wire logic [sdc_pkg::ADDR_W-1:0] addr,
  // byte-lane masks
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  // data pins
  input wire logic [sdc_pkg::DQ_W-1:0] dqIn,
  output logic [sdc_pkg::DQ_W-1:0] dqOut,
  output logic [sdc_pkg::LANES-1:0] dqOeN
);
  import sdc_pkg::*;

  // ****************************************
  // input sampling
  // ****************************************
  logic csN_reg, rasN_reg, casN_reg, weN_reg;
  logic [BANK_W-1:0] ba_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [LANES-1:0] mask_reg;
  logic [DQ_W-1:0] dq_reg;

  always_ff @(posedge clk or posedge rst) begin // RULE12
    if (rst) begin
      csN_reg <= 1'b1;
      rasN_reg <= 1'b1;
      casN_reg <= 1'b1;
      weN_reg <= 1'b1;
      ba_reg <= '0;
      addr_reg <= '0;
      mask_reg <= '1;
      dq_reg <= DQ_RESET;
    end else begin
      csN_reg <= chipSelectN;
      rasN_reg <= rowStrobeN;
      casN_reg <= colStrobeN;
      weN_reg <= writeStrobeN;
      ba_reg <= bankSel;
      addr_reg <= addr;
      mask_reg <= {high_byte_mask, low_byte_mask}; // RULE4
      dq_reg <= dqIn;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  wire logic [2:0] cmdCode = {rasN_reg, casN_reg, weN_reg}; // RULE1
  wire logic cmdLive = !csN_reg; // RULE13
  wire logic cmdActive = cmdLive && cmdCode == CMD_ACTIVE;
  wire logic cmdRead = cmdLive && cmdCode == CMD_READ;
  wire logic cmdWrite = cmdLive && cmdCode == CMD_WRITE;
  wire logic cmdPrecharge = cmdLive && cmdCode == CMD_PRECHARGE;
  wire logic cmdMode = cmdLive && cmdCode == CMD_MODE_PROGRAM;
  wire logic pcFlag = addr_reg[PRECHARGE_FLAG_POS];

  // ****************************************
  // mode register
  // ****************************************
  logic [ADDR_W-1:0] mode_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
    end else if (cmdMode) begin
      mode_reg <= addr_reg; // RULE11
    end
  end

  // full page is held to eight beats in this model
  wire logic [2:0] blCode = mode_reg[BL_MSB:BL_LSB];
  wire logic [3:0] blRemain = (blCode == BL_CODE_1) ? BL_REM_1 :
                              (blCode == BL_CODE_2) ? BL_REM_2 :
                              (blCode == BL_CODE_4) ? BL_REM_4 : BL_REM_8;

  // ****************************************
  // burst engine
  // ****************************************
  sdc_burst_t state_reg, state_next;
  logic [COL_MSB:0] col_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [3:0] remain_reg;
  logic autoPre_reg;

  // a new read or write cuts off any burst in flight
  wire logic startNow = cmdRead || cmdWrite;
  wire logic inBurst = state_reg != BS_IDLE;
  wire logic beatNow = startNow || inBurst;
  wire logic beatWrite = startNow ? cmdWrite : state_reg == BS_WRITE;
  wire logic [BANK_W-1:0] bankNow = startNow ? ba_reg : bank_reg; // RULE6
  wire logic [COL_MSB:0] colNow = startNow ? addr_reg[COL_MSB:0] : col_reg; // RULE8
  wire logic apNow = startNow ? pcFlag : autoPre_reg; // RULE9
  wire logic [3:0] remNow = startNow ? blRemain : remain_reg;
  wire logic lastBeat = beatNow && remNow == BL_REM_1;
  wire logic apClose = lastBeat && apNow; // RULE9

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BS_IDLE: begin
        if (startNow) begin
          state_next = lastBeat ? BS_IDLE : (cmdWrite ? BS_WRITE : BS_READ);
        end
      end
      BS_READ, BS_WRITE: begin
        if (startNow) begin
          state_next = lastBeat ? BS_IDLE : (cmdWrite ? BS_WRITE : BS_READ);
        end else if (lastBeat) begin
          state_next = BS_IDLE;
        end
      end
      // a corrupted one-hot code falls back to idle
      default: begin
        state_next = BS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin // RULE13
    if (rst) begin
      state_reg <= BS_IDLE;
      col_reg <= '0;
      bank_reg <= '0;
      remain_reg <= BL_REM_1;
      autoPre_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      col_reg <= colNow + 1'b1;
      bank_reg <= bankNow;
      remain_reg <= (remNow == BL_REM_1) ? BL_REM_1 : remNow - 1'b1;
      autoPre_reg <= apNow;
    end
  end

  // ****************************************
  // per-bank open row
  // ****************************************
  logic [BANKS-1:0] open_reg;
  logic [ADDR_W-1:0] row_reg [0:BANKS-1];

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : gBank
      wire logic hitCmd = ba_reg == BANK_W'(b);
      wire logic closeIt = (cmdPrecharge && (pcFlag || hitCmd)) || // RULE10
                           (apClose && bankNow == BANK_W'(b));
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          open_reg[b] <= 1'b0;
          row_reg[b] <= '0;
        end else if (cmdActive && hitCmd) begin // RULE6
          open_reg[b] <= 1'b1;
          row_reg[b] <= addr_reg; // RULE7
        end else if (closeIt) begin
          open_reg[b] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // storage access
  // ****************************************
  // only low row and column bits reach the small storage array
  wire logic [ADDR_W-1:0] rowNow = row_reg[bankNow];
  wire logic [MEM_ADDR_W-1:0] memAddr = {bankNow, rowNow[MEM_ROW_BITS-1:0], colNow[MEM_COL_BITS-1:0]};
  wire logic beatOk = beatNow && open_reg[bankNow];
  wire logic [LANES-1:0] memWrEn = {LANES{beatOk && beatWrite}} & ~mask_reg; // RULE2 RULE5
  logic [DQ_W-1:0] memRd;

  sdc_beat_mem uMem (
    .clk(clk),
    .wrEn(memWrEn),
    .addr(memAddr),
    .wrData(dq_reg),
    .rdData(memRd)
  );

  // ****************************************
  // read output path, two clocks after sampling
  // ****************************************
  logic rdStage_reg;
  logic [LANES-1:0] maskStage_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdStage_reg <= 1'b0;
      maskStage_reg <= '1;
      dqOut <= DQ_RESET;
      dqOeN <= '1;
    end else begin
      rdStage_reg <= beatOk && !beatWrite;
      maskStage_reg <= mask_reg; // RULE3
      dqOut <= memRd;
      dqOeN <= ~({LANES{rdStage_reg}} & ~maskStage_reg); // RULE3 RULE4 RULE5
    end
  end
endmodule
`default_nettype wire

// file: testbench/sdc_device_chk.sv
// pin assertions for the sdram device
`timescale 1ns/1ns
`default_nettype none
module sdc_device_chk (
  // command pins
  input wire logic clk,
  input wire logic rst,
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeStrobeN,
  input wire logic [sdc_pkg::BANK_W-1:0] bankSel,
  input wire logic [sdc_pkg::ADDR_W-1:0] addr,
  // masks and drive
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [sdc_pkg::LANES-1:0] dqOeN
);
  import sdc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] openReg, openNext, bankBit;
  logic [1:0] rdPipe;
  logic oneReg;
  wire [2:0] cmd = {rowStrobeN, colStrobeN, writeStrobeN};
  wire sel = !chipSelectN;
  wire rd = sel && cmd == CMD_READ;
  wire quiet = dqOeN == 2'h3 && rdPipe == 2'h0;
  wire hit = openReg[bankSel];
  wire flag = addr[PRECHARGE_FLAG_POS];
  wire shut = sel && (cmd == CMD_PRECHARGE || (cmd[2:1] == 2'h2 && flag));
  assign bankBit = 4'h1 << bankSel;
  assign openNext = (shut && cmd == CMD_PRECHARGE && flag) ? 4'h0 : shut ? openReg & ~bankBit
    : (sel && cmd == CMD_ACTIVE) ? openReg | bankBit : openReg;
  // ****
  // open-bank shadow
  // ****
  // auto precharge counted as closing at once; bench never reuses the bank mid-burst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      openReg <= 4'h0;
      rdPipe <= 2'h0;
      oneReg <= 1'b1;
    end else begin
      openReg <= openNext;
      rdPipe <= {rdPipe[0], rd};
      oneReg <= (sel && cmd == CMD_MODE_PROGRAM) ? addr[BL_MSB:BL_LSB] == BL_CODE_1 : oneReg;
    end
  end
  low_mask_float_a: assert property (low_byte_mask |-> ##3 dqOeN[0])
    else $error("low lane driven under mask");
  high_mask_float_a: assert property (high_byte_mask |-> ##3 dqOeN[1])
    else $error("high lane driven under mask");
  closed_read_quiet_a: assert property (rd && !hit && quiet |-> ##3 dqOeN == 2'h3)
    else $error("closed bank drove data");
  open_read_drive_a: assert property (rd && hit && !low_byte_mask && !high_byte_mask |-> ##3 dqOeN == 2'h0)
    else $error("open bank read not driven");
  deselect_ignore_a: assert property (chipSelectN && cmd == CMD_READ && hit && quiet |-> ##3 dqOeN == 2'h3)
    else $error("deselected read drove data");
  drive_origin_a: assert property (dqOeN != 2'h3 |-> $past(rdPipe[1]) || $past(dqOeN) != 2'h3)
    else $error("drive without read");
  burst_one_a: assert property (rd && hit && oneReg && !low_byte_mask && !high_byte_mask ##1 !rd
    |-> ##2 dqOeN == 2'h0 ##1 dqOeN == 2'h3) else $error("single beat burst wrong");
  reset_idle_a: assert property ($fell(rst) |-> dqOeN == 2'h3) else $error("drive after reset");
endmodule
`default_nettype wire

// file: testbench/sdc_ctrl_model.sv
// controller model driving the sdram command, address, mask and data pins
`timescale 1ns/1ns
`default_nettype none
module sdc_ctrl_model (
  // clock
  input wire logic clk,
  // pins toward the device
  output logic chipSelectN,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic writeStrobeN,
  output logic [sdc_pkg::BANK_W-1:0] bankSel,
  output logic [sdc_pkg::ADDR_W-1:0] addr,
  output logic low_byte_mask,
  output logic high_byte_mask,
  output logic [sdc_pkg::DQ_W-1:0] dqIn
);
  initial begin
    {chipSelectN, rowStrobeN, colStrobeN, writeStrobeN} = 4'hF;
    bankSel = 2'h0;
    addr = 13'h0000;
    {high_byte_mask, low_byte_mask} = 2'h0;
    dqIn = 16'h0000;
  end
  // one pin cycle; unused data pins flip so stale data never looks valid
  task automatic op(input logic s, input logic dv, input logic [2:0] c, input logic [1:0] b,
    input logic [12:0] a, input logic [15:0] d, input logic [1:0] m);
    @(posedge clk);
    chipSelectN <= !s;
    {rowStrobeN, colStrobeN, writeStrobeN} <= c;
    bankSel <= b;
    addr <= a;
    {high_byte_mask, low_byte_mask} <= m;
    dqIn <= dv ? d : ~dqIn;
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the sdram device pins
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sdc_pkg::*;
  localparam logic [17:0] IDLE = 18'h30000;
  logic clk, rst, chipSelectN, rowStrobeN, colStrobeN, writeStrobeN, low_byte_mask, high_byte_mask;
  logic [BANK_W-1:0] bankSel;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dqIn, dqOut;
  logic [LANES-1:0] dqOeN;
  int failures, total_checks, cycles;
  sdc_device i_dut (.clk, .rst, .chipSelectN, .rowStrobeN, .colStrobeN, .writeStrobeN, .bankSel, .addr,
    .low_byte_mask, .high_byte_mask, .dqIn, .dqOut, .dqOeN);
  sdc_ctrl_model i_ctl (.clk, .chipSelectN, .rowStrobeN, .colStrobeN, .writeStrobeN, .bankSel, .addr,
    .low_byte_mask, .high_byte_mask, .dqIn);
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // ****
  // helpers
  // ****
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic nop(input int n);
    repeat (n) i_ctl.op(1'b0, 1'b0, 3'h7, 2'h0, 13'h0000, 16'h0000, 2'h0);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
    i_ctl.op(1'b1, 1'b0, c, b, a, 16'h0000, 2'h0);
  endtask
  task automatic wr(input logic [2:0] c, input logic [12:0] a, input logic [15:0] d, input logic [1:0] m);
    i_ctl.op(c == CMD_WRITE, 1'b1, c, 2'h1, a, d, m);
  endtask
  // floated lanes compare as zero
  task automatic beat(input logic [17:0] e);
    nop(1);
    #1;
    chk({dqOeN, dqOeN[1] ? 8'h00 : dqOut[15:8], dqOeN[0] ? 8'h00 : dqOut[7:0]}, e);
  endtask
  task automatic rdchk(input logic s, input logic [1:0] b, input logic [12:0] a, input logic [1:0] m,
    input logic [17:0] e0, input logic [17:0] e1);
    i_ctl.op(s, 1'b0, CMD_READ, b, a, 16'h0000, m);
    i_ctl.op(1'b0, 1'b0, 3'h7, 2'h0, 13'h0000, 16'h0000, m);
    nop(1);
    beat(e0);
    beat(e1);
    beat(IDLE);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_write_read;
    cmd(CMD_ACTIVE, 2'h1, 13'h1ABC);
    wr(CMD_WRITE, 13'h0005, 16'h1122, 2'h0);
    wr(3'h7, 13'h0000, 16'h3344, 2'h0);
    wr(CMD_WRITE, 13'h0005, 16'hAAAA, 2'h2);
    wr(3'h7, 13'h0000, 16'hBBBB, 2'h1);
    rdchk(1'b1, 2'h1, 13'h0205, 2'h0, 18'h011AA, 18'h0BB44);
    rdchk(1'b1, 2'h1, 13'h0005, 2'h1, 18'h11100, 18'h1BB00);
    rdchk(1'b1, 2'h1, 13'h0005, 2'h2, 18'h200AA, 18'h20044);
    $display("write and mask test done");
  endtask
  task automatic t_banks;
    cmd(CMD_ACTIVE, 2'h2, 13'h0000);
    cmd(CMD_PRECHARGE, 2'h2, 13'h0000);
    rdchk(1'b1, 2'h2, 13'h0005, 2'h0, IDLE, IDLE);
    rdchk(1'b1, 2'h1, 13'h0405, 2'h0, 18'h011AA, 18'h0BB44);
    rdchk(1'b1, 2'h1, 13'h0005, 2'h0, IDLE, IDLE);
    cmd(CMD_ACTIVE, 2'h1, 13'h1ABC);
    rdchk(1'b0, 2'h1, 13'h0005, 2'h0, IDLE, IDLE);
    cmd(CMD_PRECHARGE, 2'h3, 13'h0400);
    rdchk(1'b1, 2'h1, 13'h0005, 2'h0, IDLE, IDLE);
    cmd(CMD_ACTIVE, 2'h1, 13'h1ABC);
    cmd(CMD_MODE_PROGRAM, 2'h0, 13'h0000);
    rdchk(1'b1, 2'h1, 13'h0005, 2'h0, 18'h011AA, IDLE);
    $display("bank and mode test done");
  endtask
  // four-beat bursts, a refused write to a closed bank, and a read cut short by a new read
  task automatic t_burst;
    cmd(CMD_MODE_PROGRAM, 2'h0, 13'h0002);
    wr(CMD_WRITE, 13'h0010, 16'h0123, 2'h0);
    wr(3'h7, 13'h0000, 16'h4567, 2'h0);
    wr(3'h7, 13'h0000, 16'h89AB, 2'h0);
    wr(3'h7, 13'h0000, 16'hCDEF, 2'h0);
    cmd(CMD_PRECHARGE, 2'h1, 13'h0000);
    wr(CMD_WRITE, 13'h0010, 16'hFFFF, 2'h0);
    nop(4);
    cmd(CMD_ACTIVE, 2'h1, 13'h1ABC);
    cmd(CMD_READ, 2'h1, 13'h0010);
    nop(1);
    cmd(CMD_READ, 2'h1, 13'h0010);
    beat(18'h00123);
    beat(18'h04567);
    beat(18'h00123);
    beat(18'h04567);
    beat(18'h089AB);
    beat(18'h0CDEF);
    beat(IDLE);
    $display("burst length test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // whole run is about 90 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      results;
    end
  end
  initial begin
    rst = 1'b1;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({dqOeN, dqOut}, IDLE);
    $display("reset test done");
    cmd(CMD_MODE_PROGRAM, 2'h0, 13'h0001);
    t_write_read;
    t_banks;
    t_burst;
    results;
  end
endmodule
bind sdc_device sdc_device_chk i_chk (.clk, .rst, .chipSelectN, .rowStrobeN, .colStrobeN, .writeStrobeN,
  .bankSel, .addr, .low_byte_mask, .high_byte_mask, .dqOeN);
`default_nettype wire
